// File: hw/dpl_pkg.sv
/*
 * Constants for the debug port link bank registers: offsets, bank codes,
 * field positions, reset values and the APB master state encoding.
 * Assumes it is compiled before every file that uses it.
 */
package dpl_pkg;

    // Byte offsets on the debug link register port
    localparam logic [7:0]  OFS_BANKED = 8'h04;
    localparam logic [7:0]  OFS_RESEND = 8'h08;
    localparam logic [7:0]  OFS_RDBUF  = 8'h0c;
    localparam logic [7:0]  OFS_SELECT = 8'h80;

    // Bank codes at the shared offset
    localparam logic [3:0]  BANK_CTRL  = 4'h0;
    localparam logic [3:0]  BANK_LINK  = 4'h1;
    localparam logic [3:0]  BANK_TID   = 4'h2;
    localparam logic [3:0]  BANK_PROTO = 4'h3;
    localparam logic [3:0]  BANK_EVENT = 4'h4;
    localparam logic [3:0]  BANK_SEL1  = 4'h5;

    // Field positions
    localparam int          TURN_LSB   = 8;
    localparam int          TURN_MSB   = 9;
    localparam int          LC_ONE_BIT = 6;
    localparam int          INST_LSB   = 28;
    localparam int          INST_MSB   = 31;
    localparam int          BANK_MSB   = 3;
    localparam int          SELHI_LSB  = 4;

    // Reset values and fixed codes
    localparam logic [31:0] LC_RESET   = 32'h00000040;
    localparam logic [1:0]  TURN_RESET = 2'h0;
    localparam logic [31:0] SEL_RESET  = 32'h00000000;
    localparam logic [31:0] BUF_RESET  = 32'h00000000;
    localparam logic [3:0]  PROTO_VER  = 4'h1;
    localparam logic        EV_RESET   = 1'h1;

    // APB master states
    typedef enum logic [1:0] {
        DPL_IDLE   = 2'b00,
        DPL_SETUP  = 2'b01,
        DPL_ACCESS = 2'b10
    } dpl_apb_e;

endpackage

// File: hw/dpl_link_bank.sv
/*
 * Debug port link bank registers with an APB master for access-port
 * transfers. The register file sits on the debug link clock; the APB
 * master runs on the system clock. Requests cross by a toggle handshake.
 * Assumes a link protocol engine on link_clock presents decoded register
 * requests and waits while link_busy is high before an access-port request.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Two-wire port has read-write link control, bit 6 reads one.
// - Scan-chain variant: link control reads zero.
// - Turnaround field codes 0..3 mean 1..4 data periods, reset one period.
// - Target identification fields come from tie-off bits through the two-stage synchroniser; bit 0 reads one.
// - Designer field is an 11-bit maker code from tie-offs.
// - Protocol id reports instance tie-off on two-wire, zero on scan-chain.
// - Protocol id low nibble always reads one.
// - Event input inverted and synchronised into the port clock domain.
// - Attention flag zero means event pending, one means none.
// - Upper select register accepts writes with no effect.
// - Resend returns last access-port or read-buffer result, no new access.
// - Scan-chain variant: resend reads zero.
// - Select register write-only, resets zero, banks and addresses.
// - APB address fixed at transfer start, held until next transfer.
// - APB address bits 1:0 are always zero.
// - APB address bits 3:2 from request, 31:4 from select.
// - Address width is a parameter, reported; select bits above ignore writes.
// - Select low nibble chooses the banked register at the shared offset.
// - Read buffer returns last access-port result without a new access; scan-chain variant: read buffer reads zero.
module dpl_link_bank #(
    parameter int ADDR_W = 32
) (
    // System clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // Debug link clock and reset
    input  wire logic              link_clock,
    input  wire logic              link_rst_n,
    // Tie-offs and trigger (asynchronous pins)
    input  wire logic              scan_chain_mode,
    input  wire logic [31:1]       target_tieoff_bus,
    input  wire logic [3:0]        instance_tieoff,
    input  wire logic              event_status_input,
    // Register requests from the link engine
    input  wire logic              link_req,
    input  wire logic              link_ap,
    input  wire logic              link_rnw,
    input  wire logic [7:0]        link_addr,
    input  wire logic [31:0]       link_wdata,
    output logic                   link_ack,
    output logic [31:0]            link_rdata,
    output logic                   link_busy,
    output logic [1:0]             turnaround_period,
    // APB master
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic [ADDR_W-1:0]      paddr,
    output logic [31:0]            pwdata,
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    output logic [7:0]             addr_size_field
);

    // Select bits above the address width never store
    localparam logic [63:0] WIDE_MASK = (64'h1 << ADDR_W) - 64'h1;
    localparam logic [31:0] SEL_MASK  = WIDE_MASK[31:0] | 32'h0000000f;

    // Link domain state
    logic [35:0] tie_s1;
    logic [35:0] tie_s2;
    logic        ev_s1;
    logic        ev_s2;
    logic        ack_s1;
    logic        ack_s2;
    logic        ack_s3;
    logic [1:0]  turn;
    logic [31:0] sel;
    logic [31:0] last_ap;
    logic [31:0] resend_val;
    logic        req_tgl;
    logic [31:0] hold_addr;
    logic [31:0] hold_wdata;
    logic        hold_rnw;
    logic [1:0]  next_turn;
    logic [31:0] next_sel;
    logic [31:0] next_last_ap;
    logic [31:0] next_resend_val;
    logic        next_req_tgl;
    logic        next_link_busy;
    logic [31:0] next_hold_addr;
    logic [31:0] next_hold_wdata;
    logic        next_hold_rnw;
    logic [31:0] next_link_rdata;
    logic        next_link_ack;
    logic [31:0] rd;
    logic        scan;
    logic [3:0]  bank;

    // System domain state
    dpl_pkg::dpl_apb_e state;
    dpl_pkg::dpl_apb_e next_state;
    logic        req_s1;
    logic        req_s2;
    logic        req_s3;
    logic        ack_tgl;
    logic [31:0] ap_rdata;
    logic        next_ack_tgl;
    logic [31:0] next_ap_rdata;
    logic        next_psel;
    logic        next_penable;
    logic        next_pwrite;
    logic [ADDR_W-1:0] next_paddr;
    logic [31:0] next_pwdata;

    assign scan = tie_s2[35];
    assign bank = sel[dpl_pkg::BANK_MSB:0];

    // Pin and handshake synchronisers on the link clock; first stage feeds only the second
    always_ff @(posedge link_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tie_s1 <= 36'h0;
            tie_s2 <= 36'h0;
            ev_s1  <= dpl_pkg::EV_RESET;
            ev_s2  <= dpl_pkg::EV_RESET;
            ack_s1 <= 1'h0;
            ack_s2 <= 1'h0;
            ack_s3 <= 1'h0;
        end else begin
            tie_s1 <= {scan_chain_mode, instance_tieoff, target_tieoff_bus};
            tie_s2 <= tie_s1;
            ev_s1  <= ~event_status_input;
            ev_s2  <= ev_s1;
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
        end
    end

    // Register file: decode of reads and writes, and access-port launch
    always_comb begin
        next_turn       = turn;
        next_sel        = sel;
        next_last_ap    = last_ap;
        next_resend_val = resend_val;
        next_req_tgl    = req_tgl;
        next_link_busy  = link_busy;
        next_hold_addr  = hold_addr;
        next_hold_wdata = hold_wdata;
        next_hold_rnw   = hold_rnw;
        next_link_rdata = link_rdata;
        next_link_ack   = 1'h0;
        rd              = 32'h0;
        // Completion: ap_rdata is stable once the toggle is seen
        if (ack_s2 ^ ack_s3) begin
            next_link_busy = 1'h0;
            if (hold_rnw) begin
                next_last_ap = ap_rdata;
            end
        end
        if (link_req && link_ap) begin
            // A second transfer while one is in flight is refused
            if (!link_busy) begin
                next_link_ack   = 1'h1;
                next_link_busy  = 1'h1;
                next_req_tgl    = ~req_tgl;
                next_hold_addr  = {sel[31:dpl_pkg::SELHI_LSB], link_addr[3:2], 2'h0};
                next_hold_wdata = link_wdata;
                next_hold_rnw   = link_rnw;
                if (link_rnw) begin
                    // Posted read: the previous result comes back now
                    rd              = last_ap;
                    next_resend_val = last_ap;
                end
            end
        end else if (link_req && link_rnw) begin
            next_link_ack = 1'h1;
            unique case (link_addr)
                dpl_pkg::OFS_BANKED: begin
                    unique case (bank)
                        dpl_pkg::BANK_LINK: begin
                            if (!scan) begin
                                rd[dpl_pkg::TURN_MSB:dpl_pkg::TURN_LSB] = turn;
                                rd[dpl_pkg::LC_ONE_BIT] = 1'h1;
                            end
                        end
                        dpl_pkg::BANK_TID: begin
                            rd = {tie_s2[30:0], 1'h1};
                        end
                        dpl_pkg::BANK_PROTO: begin
                            rd[3:0] = dpl_pkg::PROTO_VER;
                            if (!scan) begin
                                rd[dpl_pkg::INST_MSB:dpl_pkg::INST_LSB] = tie_s2[34:31];
                            end
                        end
                        dpl_pkg::BANK_EVENT: begin
                            rd[0] = ev_s2;
                        end
                        default: begin
                            rd = 32'h0;
                        end
                    endcase
                end
                dpl_pkg::OFS_RESEND: begin
                    rd = scan ? 32'h0 : resend_val;
                end
                dpl_pkg::OFS_RDBUF: begin
                    if (!scan) begin
                        rd              = last_ap;
                        next_resend_val = last_ap;
                    end
                end
                default: begin
                    rd = 32'h0;
                end
            endcase
        end else if (link_req) begin
            next_link_ack = 1'h1;
            if (link_addr == dpl_pkg::OFS_SELECT) begin
                next_sel = link_wdata & SEL_MASK;
            end else if (link_addr == dpl_pkg::OFS_BANKED &&
                         bank == dpl_pkg::BANK_LINK && !scan) begin
                next_turn = link_wdata[dpl_pkg::TURN_MSB:dpl_pkg::TURN_LSB];
            end
            // Upper select and all other banks drop writes
        end
        if (next_link_ack) begin
            next_link_rdata = rd;
        end
    end

    // Register file flops
    always_ff @(posedge link_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            turn              <= dpl_pkg::TURN_RESET;
            sel               <= dpl_pkg::SEL_RESET;
            last_ap           <= dpl_pkg::BUF_RESET;
            resend_val        <= dpl_pkg::BUF_RESET;
            req_tgl           <= 1'h0;
            link_busy         <= 1'h0;
            hold_addr         <= 32'h0;
            hold_wdata        <= 32'h0;
            hold_rnw          <= 1'h0;
            link_rdata        <= 32'h0;
            link_ack          <= 1'h0;
            turnaround_period <= dpl_pkg::TURN_RESET;
        end else begin
            turn              <= next_turn;
            sel               <= next_sel;
            last_ap           <= next_last_ap;
            resend_val        <= next_resend_val;
            req_tgl           <= next_req_tgl;
            link_busy         <= next_link_busy;
            hold_addr         <= next_hold_addr;
            hold_wdata        <= next_hold_wdata;
            hold_rnw          <= next_hold_rnw;
            link_rdata        <= next_link_rdata;
            link_ack          <= next_link_ack;
            turnaround_period <= next_turn;
        end
    end

    // APB master: launches on a request toggle, answers with an ack toggle
    always_comb begin
        next_state    = state;
        next_ack_tgl  = ack_tgl;
        next_ap_rdata = ap_rdata;
        next_psel     = psel;
        next_penable  = penable;
        next_pwrite   = pwrite;
        next_paddr    = paddr;
        next_pwdata   = pwdata;
        unique case (state)
            dpl_pkg::DPL_IDLE: begin
                if (req_s2 ^ req_s3) begin
                    // Hold fields are frozen while the link side is busy
                    next_paddr  = hold_addr[ADDR_W-1:0];
                    next_pwrite = ~hold_rnw;
                    next_pwdata = hold_wdata;
                    next_psel   = 1'h1;
                    next_state  = dpl_pkg::DPL_SETUP;
                end
            end
            dpl_pkg::DPL_SETUP: begin
                next_penable = 1'h1;
                next_state   = dpl_pkg::DPL_ACCESS;
            end
            dpl_pkg::DPL_ACCESS: begin
                if (pready) begin
                    next_psel    = 1'h0;
                    next_penable = 1'h0;
                    next_ack_tgl = ~ack_tgl;
                    if (!pwrite) begin
                        next_ap_rdata = prdata;
                    end
                    next_state = dpl_pkg::DPL_IDLE;
                end
            end
            default: begin
                next_psel    = 1'h0;
                next_penable = 1'h0;
                next_state   = dpl_pkg::DPL_IDLE;
            end
        endcase
    end

    // APB master flops; paddr changes only when a transfer starts
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state           <= dpl_pkg::DPL_IDLE;
            req_s1          <= 1'h0;
            req_s2          <= 1'h0;
            req_s3          <= 1'h0;
            ack_tgl         <= 1'h0;
            ap_rdata        <= dpl_pkg::BUF_RESET;
            psel            <= 1'h0;
            penable         <= 1'h0;
            pwrite          <= 1'h0;
            paddr           <= '0;
            pwdata          <= 32'h0;
            addr_size_field <= 8'(ADDR_W);
        end else begin
            state           <= next_state;
            req_s1          <= req_tgl;
            req_s2          <= req_s1;
            req_s3          <= req_s2;
            ack_tgl         <= next_ack_tgl;
            ap_rdata        <= next_ap_rdata;
            psel            <= next_psel;
            penable         <= next_penable;
            pwrite          <= next_pwrite;
            paddr           <= next_paddr;
            pwdata          <= next_pwdata;
            addr_size_field <= 8'(ADDR_W);
        end
    end

endmodule

`default_nettype wire

// File: dv/dpl_link_bank_sva.sv
/* Checker for the link bank ports: APB address form and timing, busy and
 * turnaround updates. Assumes it is bound onto every dpl_link_bank. */
`timescale 1ns/1ps
`default_nettype none
module dpl_link_bank_sva #(
    parameter int ADDR_W = 32
) (
    // Clocks and resets
    input wire logic              clock,
    input wire logic              rst_n,
    input wire logic              link_clock,
    input wire logic              link_rst_n,
    // Link port
    input wire logic              link_req,
    input wire logic              link_ap,
    input wire logic              link_rnw,
    input wire logic              link_busy,
    input wire logic [7:0]        link_addr,
    input wire logic [1:0]        turnaround_period,
    // APB master
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [7:0]        addr_size_field
);
    logic [1:0] ap_word;
    // Word offset of the last accepted transfer; refused ones must not count
    always_ff @(posedge link_clock or negedge link_rst_n) begin
        if (!link_rst_n) begin
            ap_word <= 2'h0;
        end else if (link_req && link_ap && !link_busy) begin
            ap_word <= link_addr[3:2];
        end
    end
    AST_PADDR_ALIGNED: assert property (@(posedge clock) disable iff (!rst_n)
        psel |-> paddr[1:0] == 2'h0) else $error("paddr not word aligned");
    AST_PADDR_HELD: assert property (@(posedge clock) disable iff (!rst_n)
        !$rose(psel) |-> $stable(paddr)) else $error("paddr moved inside a transfer");
    AST_APB_PHASES: assert property (@(posedge clock) disable iff (!rst_n)
        psel && !penable |=> psel && penable && $stable(paddr))
        else $error("setup phase not followed by access phase");
    AST_PADDR_WORD: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(psel) |-> paddr[3:2] == ap_word) else $error("paddr word bits wrong");
    AST_NO_SPARE_APB: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(psel) |-> link_busy) else $error("APB transfer without request");
    AST_BUSY_CAUSE: assert property (@(posedge link_clock) disable iff (!link_rst_n)
        $rose(link_busy) |-> $past(link_req && link_ap)) else $error("busy without request");
    AST_TURN_CAUSE: assert property (@(posedge link_clock) disable iff (!link_rst_n)
        $changed(turnaround_period) |-> $past(link_req && !link_rnw)
        || $past(link_req && !link_rnw, 2)) else $error("turnaround changed unasked");
    AST_ADDR_SIZE_FIELD: assert property (@(posedge clock) disable iff (!rst_n)
        addr_size_field == 8'(ADDR_W)) else $error("address size field wrong");
endmodule
bind dpl_link_bank dpl_link_bank_sva #(.ADDR_W(ADDR_W)) sva_inst (.clock, .rst_n,
    .link_clock, .link_rst_n, .link_req, .link_ap, .link_rnw, .link_busy, .link_addr,
    .turnaround_period, .psel, .penable, .paddr, .addr_size_field);
`default_nettype wire

// File: dv/dpl_apb_slave.sv
/* APB target model behind the link bank, with a settable number of wait
 * states. Assumes a 24-bit address; writes are answered and dropped. */
`timescale 1ns/1ps
`default_nettype none
module dpl_apb_slave (
    // Clock, reset and pacing
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [2:0]  wait_states,
    // APB target side
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic [23:0] paddr,
    output logic [31:0]      prdata,
    output logic             pready
);
    logic [2:0]  waited;
    logic [31:0] word;
    // Data is a pattern of the address so the bench can predict it
    assign word = 32'h5a00_0000 ^ {8'h00, paddr};
    // Wait states count only inside the access phase
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            waited <= 3'h0;
        end else if (psel && penable && !pready) begin
            waited <= waited + 3'h1;
        end else begin
            waited <= 3'h0;
        end
    end
    assign pready = psel && penable && (waited == wait_states);
    // Outside the answer the lines carry garbage, never the word
    assign prdata = pready ? word : ~word;
endmodule
`default_nettype wire

// File: dv/tb_top.sv
/* Self-checking bench for the link bank: register tasks on the link port
 * and an APB target model. Assumes the package, design and model files. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int          AW     = 24;
    localparam logic [31:1] TIE_ID = 31'h1234_5677; // Arbitrary value
    localparam logic [3:0]  INST   = 4'h9;
    logic          clock, rst_n, link_clock, link_rst_n, scan_chain_mode, event_status_input;
    logic          link_req, link_ap, link_rnw, link_ack, link_busy, psel, penable, pready;
    logic          pwrite;
    logic [7:0]    link_addr, addr_size_field;
    logic [31:0]   link_wdata, link_rdata, prdata, rdat, pwdata;
    logic [1:0]    turnaround_period;
    logic [AW-1:0] paddr;
    logic [2:0]    wait_states;
    logic [3:0]    spare [4] = '{4'h0, 4'h5, 4'h6, 4'hf};
    int            miscompares, comparisons;

    dpl_link_bank #(.ADDR_W(AW)) dpl_link_bank_inst (.clock, .rst_n, .link_clock, .link_rst_n,
        .scan_chain_mode, .target_tieoff_bus(TIE_ID), .instance_tieoff(INST),
        .event_status_input, .link_req, .link_ap, .link_rnw, .link_addr, .link_wdata,
        .link_ack, .link_rdata, .link_busy, .turnaround_period, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .addr_size_field);
    dpl_apb_slave dpl_apb_slave_inst (.clock, .rst_n, .wait_states, .psel, .penable, .paddr,
        .prdata, .pready);

    // System clock; the link clock starts off phase so edges never meet
    always #5 clock = ~clock;
    initial begin
        #3;
        forever #80 link_clock = ~link_clock;
    end

    function automatic logic [31:0] word(input logic [23:0] a);
        return 32'h5a00_0000 ^ {8'h00, a};
    endfunction
    // Compare one word and count it
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // Wait out any transfer so buffers are settled, pulse one request, take the ack
    task automatic acc(input logic ap, input logic rnw, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(negedge link_clock);
        while (link_busy && n < 32) begin
            @(negedge link_clock);
            n++;
        end
        link_req = 1'b1;
        link_ap = ap;
        link_rnw = rnw;
        link_addr = a;
        link_wdata = d;
        @(negedge link_clock);
        link_req = 1'b0;
        chk("link_ack", 32'h1, {31'h0, link_ack});
        rdat = link_rdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b0, 1'b0, a, d);
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, 1'b1, a, 32'h0);
        chk(n, e, rdat);
    endtask
    task automatic sel(input logic [31:0] d);
        wr(dpl_pkg::OFS_SELECT, d);
    endtask
    task automatic rb(input string n, input logic [31:0] e);
        rd(n, dpl_pkg::OFS_BANKED, e);
    endtask
    task automatic final_report;
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Cut a hang short; the sequence needs well under 100 us
    initial begin
        #500_000;
        miscompares++;
        final_report();
    end

    initial begin
        clock = 1'b0;
        link_clock = 1'b0;
        rst_n = 1'b0;
        link_rst_n = 1'b0;
        scan_chain_mode = 1'b0;
        event_status_input = 1'b0;
        link_req = 1'b0;
        link_ap = 1'b0;
        link_rnw = 1'b0;
        link_addr = 8'h00;
        link_wdata = 32'h0;
        wait_states = 3'h0;
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        repeat (2) @(negedge link_clock);
        link_rst_n = 1'b1;
        repeat (3) @(negedge link_clock);
        // Link control defaults, then every turnaround code; bit 6 stays one
        chk("turnaround", 32'h0, {30'h0, turnaround_period});
        sel(32'h1);
        rb("link_control", dpl_pkg::LC_RESET);
        for (int i = 0; i < 4; i++) begin
            wr(dpl_pkg::OFS_BANKED, 32'(i) << 8);
            rb("link_control", 32'h40 | (32'(i) << 8));
            chk("turnaround", 32'(i), {30'h0, turnaround_period});
        end
        // Identification banks; a write to a read-only bank is dropped
        sel(32'h2);
        wr(dpl_pkg::OFS_BANKED, 32'h0);
        rb("target_id", {TIE_ID, 1'b1});
        sel(32'h3);
        rb("protocol_id", {INST, 24'h0, dpl_pkg::PROTO_VER});
        // Event flag is the inverse of the trigger once synchronised
        sel(32'h4);
        event_status_input = 1'b1;
        repeat (4) @(negedge link_clock);
        rb("event_flag", 32'h0);
        event_status_input = 1'b0;
        repeat (4) @(negedge link_clock);
        rb("event_flag", 32'h1);
        // Spare banks read zero and leave link control alone
        foreach (spare[i]) begin
            sel({28'h0, spare[i]});
            wr(dpl_pkg::OFS_BANKED, 32'hffff_ffff);
            rb("spare_bank", 32'h0);
        end
        rd("unmapped", 8'h10, 32'h0);
        sel(32'h1);
        rb("link_control", 32'h340);
        // Posted transfers: fast then slow target, then resend and read buffer
        sel(32'hfe12_3450);
        acc(1'b1, 1'b1, 8'h0c, 32'h0);
        chk("ap_first", dpl_pkg::BUF_RESET, rdat);
        wait_states = 3'h3;
        acc(1'b1, 1'b1, 8'h04, 32'h0);
        chk("ap_second", word(24'h12345c), rdat);
        rd("resend", dpl_pkg::OFS_RESEND, word(24'h12345c));
        chk("paddr", 32'h12_3454, {8'h0, paddr});
        rd("read_buffer", dpl_pkg::OFS_RDBUF, word(24'h123454));
        rd("resend", dpl_pkg::OFS_RESEND, word(24'h123454));
        rd("read_buffer", dpl_pkg::OFS_RDBUF, word(24'h123454));
        // An access-port write drives the APB write lines and leaves the read buffer
        acc(1'b1, 1'b0, 8'h08, 32'hc0de_0123);
        repeat (2) @(negedge link_clock);
        chk("pwrite", 32'h1, {31'h0, pwrite});
        chk("pwdata", 32'hc0de_0123, pwdata);
        chk("paddr", 32'h12_3458, {8'h0, paddr});
        rd("read_buffer", dpl_pkg::OFS_RDBUF, word(24'h123454));
        chk("addr_size", 32'(AW), {24'h0, addr_size_field});
        // Scan-chain variant hides link control and resend
        scan_chain_mode = 1'b1;
        repeat (4) @(negedge link_clock);
        sel(32'h1);
        wr(dpl_pkg::OFS_BANKED, 32'h0);
        rb("link_control", 32'h0);
        chk("turnaround", 32'h3, {30'h0, turnaround_period});
        rd("resend", dpl_pkg::OFS_RESEND, 32'h0);
        sel(32'h3);
        rb("protocol_id", {28'h0, dpl_pkg::PROTO_VER});
        final_report();
    end
endmodule
`default_nettype wire
